// File: design/pwm_shutdown_regs.svh
// Register offsets, field positions, reset values and counts for the shutdown PWM block
`ifndef PWM_SHUTDOWN_REGS_SVH
`define PWM_SHUTDOWN_REGS_SVH
// ===========================================================
// Byte offsets on the register bus
`define OFF_TIMER_COUNT  8'h00
`define OFF_TIMER_PERIOD 8'h04
`define OFF_TIMER_CTRL   8'h08
`define OFF_DUTY_HIGH    8'h0C
`define OFF_DUTY_LOW     8'h10
`define OFF_PWM_CTRL     8'h14
`define OFF_SHUT_CTRL    8'h18
`define OFF_DEAD_BAND    8'h1C
`define OFF_IRQ_STATUS   8'h20
`define OFF_IRQ_MASK     8'h24
`define OFF_MISC_CTRL    8'h28
// ===========================================================
// Field positions
`define SHUT_FLAG_BIT    7
`define TMR_RUN_BIT      2
`define MISC_EXT_EN_BIT  0
`define IRQ_PERIOD_BIT   0
`define IRQ_SHUT_BIT     1
// ===========================================================
// Reset values
`define RST_TIMER_PERIOD 8'hFF
`define RST_BYTE         8'h00
// ===========================================================
// Prescale terminal counts, in device clocks minus one
`define PRESC_END_1      6'h03
`define PRESC_END_4      6'h0F
`define PRESC_END_16     6'h3F
`endif

// File: design/pwm_shutdown_pkg.sv
// Types shared by the shutdown PWM block
package pwm_shutdown_pkg;
    // Output steering chosen by the top two bits of pwm_control
    typedef enum logic [1:0]
    {
        OUT_SINGLE   = 2'b00,
        OUT_FULL_FWD = 2'b01,
        OUT_HALF     = 2'b10,
        OUT_FULL_REV = 2'b11
    } out_config_t;
    // Bus answers
    typedef enum logic [1:0]
    {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } resp_t;
endpackage

// File: design/pwm_auto_shutdown.sv
// Enhanced PWM with auto-shutdown, timer2-style timebase and AXI4-Lite registers
`timescale 1ns/1ps
`include "pwm_shutdown_regs.svh"
module pwm_auto_shutdown
#(
    parameter int ADDR_W = 8                    // Register bus address width
)
(
    input  wire logic              aclk,          // Device clock, 20 MHz
    input  wire logic              aresetn,       // Synchronous reset, low
    input  wire logic              por_reset,     // High when reset is power-on
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
    input  wire logic              s_axi_awvalid, // Write address valid
    output logic                   s_axi_awready, // Write address ready
    input  wire logic [31:0]       s_axi_wdata,   // Write data
    input  wire logic [3:0]        s_axi_wstrb,   // Write strobes
    input  wire logic              s_axi_wvalid,  // Write data valid
    output logic                   s_axi_wready,  // Write data ready
    output logic [1:0]             s_axi_bresp,   // Write response
    output logic                   s_axi_bvalid,  // Write response valid
    input  wire logic              s_axi_bready,  // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
    input  wire logic              s_axi_arvalid, // Read address valid
    output logic                   s_axi_arready, // Read address ready
    output logic [31:0]            s_axi_rdata,   // Read data
    output logic [1:0]             s_axi_rresp,   // Read response
    output logic                   s_axi_rvalid,  // Read data valid
    input  wire logic              s_axi_rready,  // Read data ready
    input  wire logic              comp1_out,     // Comparator 1 output
    input  wire logic              comp2_out,     // Comparator 2 output
    input  wire logic              ext_irq_zero_line, // External interrupt zero
    output logic                   output_a,      // Pin A level
    output logic                   output_a_oe,   // Pin A drive enable
    output logic                   output_b,      // Pin B level
    output logic                   output_b_oe,   // Pin B drive enable
    output logic                   output_c,      // Pin C level
    output logic                   output_c_oe,   // Pin C drive enable
    output logic                   output_d,      // Pin D level
    output logic                   output_d_oe,   // Pin D drive enable
    output logic                   irq            // Level interrupt
);
    // ===========================================================
    // Source decode, shared by the raw and filtered paths
    function automatic logic src_sel(input logic [2:0] sel, input logic c1,
                                     input logic c2, input logic ext);
        src_sel = (sel[0] & c1) | (sel[1] & c2) | (sel[2] & ext);
    endfunction

    // ===========================================================
    // Registers
    logic [7:0] timer_count_q;      // Timebase count
    logic [7:0] timer_period_q;     // Period limit
    logic [6:0] timer_control_q;    // Postscale, run, prescale
    logic [7:0] duty_high_q;        // Duty latched at period start
    logic [1:0] duty_lsb_q;         // Fine duty latched at period start
    logic [7:0] duty_low_q;         // Duty written by software
    logic [7:0] pwm_control_q;      // Config, fine duty, mode
    logic [2:0] shutdown_source_select_q; // Shutdown sources
    logic [1:0] ac_pins_shutdown_state_q; // A/C shutdown state
    logic [1:0] bd_pins_shutdown_state_q; // B/D shutdown state
    logic       shutdown_event_flag_q;    // Sticky event flag
    logic [7:0] dead_band_count_q;  // Dead band in instruction cycles
    logic [1:0] status_q;           // Sticky interrupt status
    logic [1:0] mask_q;             // Interrupt mask
    logic       ext_irq_zero_enable_q;    // Interrupt line enable
    logic [5:0] presc_q;            // Prescale counter
    logic [3:0] post_q;             // Postscale counter
    logic       run_q;              // Current period may drive
    logic [9:0] db_q;               // Dead band countdown
    logic       pwm_prev_q;         // Last modulation level
    logic [3:0] lvl_q;              // Registered pin levels D..A
    logic [3:0] en_q;               // Registered pin enables D..A
    logic       irq_q;              // Interrupt output
    logic [2:0] s1_q, s2_q, s3_q;   // Synchroniser stages
    logic [2:0] filt_q;             // Agreed pin levels
    logic [ADDR_W-1:0] awaddr_q;    // Held write address
    logic [31:0] wdata_q;           // Held write data
    logic       wstrb0_q;           // Held low-lane strobe
    logic       aw_have_q;          // Address held
    logic       w_have_q;           // Data held
    logic       awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;   // Answers
    logic [31:0] rdata_q;           // Read data

    // ===========================================================
    // Pin synchronisers, three stages each
    wire [2:0] pin_raw = {ext_irq_zero_line, comp2_out, comp1_out};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            // Only stages two and three are looked at
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    s1_q[gi]   <= 1'b0;
                    s2_q[gi]   <= 1'b0;
                    s3_q[gi]   <= 1'b0;
                    filt_q[gi] <= 1'b0;
                end
                else
                begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi])
                        filt_q[gi] <= s3_q[gi];
                end
            end
        end
    endgenerate

    // ===========================================================
    // Bus decode
    wire wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
    wire wr_ok    = wr_fire & wstrb0_q;
    wire [7:0] wb = wdata_q[7:0];
    wire [7:0] wa = 8'(awaddr_q);
    wire [7:0] ra = 8'(s_axi_araddr);
    wire ar_fire  = s_axi_arvalid & arready_q;
    wire w_tc   = wr_ok & (wa == `OFF_TIMER_COUNT);
    wire w_tp   = wr_ok & (wa == `OFF_TIMER_PERIOD);
    wire w_tcl  = wr_ok & (wa == `OFF_TIMER_CTRL);
    wire w_dh   = wr_ok & (wa == `OFF_DUTY_HIGH);
    wire w_dl   = wr_ok & (wa == `OFF_DUTY_LOW);
    wire w_pc   = wr_ok & (wa == `OFF_PWM_CTRL);
    wire w_sc   = wr_ok & (wa == `OFF_SHUT_CTRL);
    wire w_db   = wr_ok & (wa == `OFF_DEAD_BAND);
    wire w_mk   = wr_ok & (wa == `OFF_IRQ_MASK);
    wire w_mc   = wr_ok & (wa == `OFF_MISC_CTRL);
    wire wa_hit = (wa <= `OFF_MISC_CTRL) & (wa[1:0] == 2'b00);
    wire ra_hit = (ra <= `OFF_MISC_CTRL) & (ra[1:0] == 2'b00);
    wire rd_clr = ar_fire & (ra == `OFF_IRQ_STATUS);

    // ===========================================================
    // Shutdown sources and event flag
    wire pwm_mode = (pwm_control_q[3:2] == 2'b11);
    wire src_raw  = src_sel(shutdown_source_select_q, comp1_out, comp2_out,
                            ext_irq_zero_line & ext_irq_zero_enable_q);
    wire src_sync = src_sel(shutdown_source_select_q, filt_q[0], filt_q[1],
                            filt_q[2] & ext_irq_zero_enable_q);
    wire sw_set   = w_sc & wb[`SHUT_FLAG_BIT];
    wire sw_clr   = w_sc & ~wb[`SHUT_FLAG_BIT];
    // Hardware set beats a clear in the same cycle
    wire flag_d   = (pwm_mode & src_sync) | sw_set
                  | (shutdown_event_flag_q & ~sw_clr);

    // ===========================================================
    // Timebase
    logic [5:0] presc_end;
    logic [1:0] fine;
    always_comb
    begin
        // Terminal count and fine duty bits per prescale
        unique case (timer_control_q[1:0])
            2'b00:   begin presc_end = `PRESC_END_1;  fine = presc_q[1:0]; end
            2'b01:   begin presc_end = `PRESC_END_4;  fine = presc_q[3:2]; end
            default: begin presc_end = `PRESC_END_16; fine = presc_q[5:4]; end
        endcase
    end
    wire tmr_run    = timer_control_q[`TMR_RUN_BIT];
    wire tick       = tmr_run & (presc_q >= presc_end);
    wire period_end = tick & (timer_count_q == timer_period_q);
    wire post_hit   = period_end & (post_q == timer_control_q[6:3]);
    wire pwm_on     = {timer_count_q, fine} < {duty_high_q, duty_lsb_q};
    wire [1:0] irq_set = {flag_d & ~shutdown_event_flag_q, post_hit};

    // ===========================================================
    // Steering into active levels and enables per output mode
    pwm_shutdown_pkg::out_config_t cfg;
    assign cfg = pwm_shutdown_pkg::out_config_t'(pwm_control_q[7:6]);
    // Also closed in the swap cycle itself, before the countdown is loaded
    wire db_idle = (db_q == 10'h000) & (pwm_on == pwm_prev_q);
    logic [3:0] act, en;
    always_comb
    begin
        unique case (cfg)
            pwm_shutdown_pkg::OUT_SINGLE:
            begin
                act = {3'b000, pwm_on};
                en  = 4'b0001;
            end
            pwm_shutdown_pkg::OUT_FULL_FWD:
            begin
                act = {pwm_on, 3'b001};
                en  = 4'b1111;
            end
            pwm_shutdown_pkg::OUT_HALF:
            begin
                // Turn-on waits out the dead band after any swap
                act = {2'b00, ~pwm_on & db_idle, pwm_on & db_idle};
                en  = 4'b0011;
            end
            pwm_shutdown_pkg::OUT_FULL_REV:
            begin
                act = {2'b01, pwm_on, 1'b0};
                en  = 4'b1111;
            end
        endcase
    end
    // Mode bit 1 inverts A/C, bit 0 inverts B/D
    wire [3:0] pol = {pwm_control_q[0], pwm_control_q[1], pwm_control_q[0], pwm_control_q[1]};

    // ===========================================================
    // Output override; the raw source path bypasses every flop so the
    // bridge is released within gate delays, not a clock later
    wire shut = pwm_mode & (shutdown_event_flag_q | src_raw | ~run_q);
    wire [3:0] shut_lvl = {bd_pins_shutdown_state_q[0], ac_pins_shutdown_state_q[0],
                           bd_pins_shutdown_state_q[0], ac_pins_shutdown_state_q[0]};
    wire [3:0] shut_z   = {bd_pins_shutdown_state_q[1], ac_pins_shutdown_state_q[1],
                           bd_pins_shutdown_state_q[1], ac_pins_shutdown_state_q[1]};
    wire [3:0] pin_lvl  = shut ? shut_lvl : lvl_q;
    wire [3:0] pin_en   = shut ? (en_q & ~shut_z) : en_q;
    assign {output_d, output_c, output_b, output_a}         = pin_lvl;
    assign {output_d_oe, output_c_oe, output_b_oe, output_a_oe} = pin_en;

    // ===========================================================
    // Timebase, duty latch, dead band and pin registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            presc_q       <= 6'h00;
            post_q        <= 4'h0;
            timer_count_q <= `RST_BYTE;
            duty_high_q   <= `RST_BYTE;
            duty_lsb_q    <= 2'b00;
            run_q         <= 1'b1;
            db_q          <= 10'h000;
            pwm_prev_q    <= 1'b0;
            lvl_q         <= 4'h0;
            en_q          <= 4'h0;
        end
        else
        begin
            presc_q <= (!tmr_run || tick) ? 6'h00 : presc_q + 6'h01;
            if (w_tc)
                timer_count_q <= wb;
            else if (period_end)
                timer_count_q <= `RST_BYTE;
            else if (tick)
                timer_count_q <= timer_count_q + 8'h01;
            if (period_end)
            begin
                post_q      <= post_hit ? 4'h0 : post_q + 4'h1;
                duty_high_q <= duty_low_q;
                duty_lsb_q  <= pwm_control_q[5:4];
            end
            else if (w_dh)
                duty_high_q <= wb;
            // A period begun under shutdown is dropped whole
            run_q <= period_end ? ~flag_d : (run_q & ~flag_d);
            pwm_prev_q <= pwm_on;
            if (pwm_on != pwm_prev_q)
                db_q <= {dead_band_count_q, 2'b00};
            else if (!db_idle)
                db_q <= db_q - 10'h001;
            lvl_q <= act ^ pol;
            en_q  <= pwm_mode ? en : 4'h0;
        end
    end

    // ===========================================================
    // Software registers, flag and interrupt status
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_period_q           <= `RST_TIMER_PERIOD;
            timer_control_q          <= 7'h00;
            pwm_control_q            <= `RST_BYTE;
            shutdown_source_select_q <= 3'b000;
            ac_pins_shutdown_state_q <= 2'b00;
            bd_pins_shutdown_state_q <= 2'b00;
            shutdown_event_flag_q    <= 1'b0;
            status_q                 <= 2'b00;
            mask_q                   <= 2'b00;
            ext_irq_zero_enable_q    <= 1'b0;
            irq_q                    <= 1'b0;
            if (por_reset)
            begin
                dead_band_count_q <= `RST_BYTE;
                duty_low_q        <= `RST_BYTE;
            end
        end
        else
        begin
            if (w_tp)  timer_period_q  <= wb;
            if (w_tcl) timer_control_q <= wb[6:0];
            if (w_dl)  duty_low_q      <= wb;
            if (w_pc)  pwm_control_q   <= wb;
            if (w_db)  dead_band_count_q <= wb;
            if (w_mk)  mask_q          <= wb[1:0];
            if (w_mc)  ext_irq_zero_enable_q <= wb[`MISC_EXT_EN_BIT];
            if (w_sc)
            begin
                shutdown_source_select_q <= wb[6:4];
                ac_pins_shutdown_state_q <= wb[3:2];
                bd_pins_shutdown_state_q <= wb[1:0];
            end
            shutdown_event_flag_q <= flag_d;
            // New events win over the read that clears
            status_q <= irq_set | (status_q & ~{2{rd_clr}});
            irq_q    <= |((irq_set | (status_q & ~{2{rd_clr}})) & mask_q);
        end
    end

    // ===========================================================
    // Read mux
    logic [7:0] rd_byte;
    always_comb
    begin
        unique case (ra)
            `OFF_TIMER_COUNT:  rd_byte = timer_count_q;
            `OFF_TIMER_PERIOD: rd_byte = timer_period_q;
            `OFF_TIMER_CTRL:   rd_byte = {1'b0, timer_control_q};
            `OFF_DUTY_HIGH:    rd_byte = duty_high_q;
            `OFF_DUTY_LOW:     rd_byte = duty_low_q;
            `OFF_PWM_CTRL:     rd_byte = pwm_control_q;
            `OFF_SHUT_CTRL:    rd_byte = {shutdown_event_flag_q, shutdown_source_select_q,
                                          ac_pins_shutdown_state_q, bd_pins_shutdown_state_q};
            `OFF_DEAD_BAND:    rd_byte = dead_band_count_q;
            `OFF_IRQ_STATUS:   rd_byte = {6'h00, status_q};
            `OFF_IRQ_MASK:     rd_byte = {6'h00, mask_q};
            `OFF_MISC_CTRL:    rd_byte = {7'h00, ext_irq_zero_enable_q};
            default:           rd_byte = 8'h00;
        endcase
    end

    // ===========================================================
    // AXI4-Lite handshakes; address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'b00;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb0_q  <= 1'b0;
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'b00;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awvalid && awready_q)
            begin
                awaddr_q  <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q)
            begin
                wdata_q  <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (wr_fire)
            begin
                bvalid_q  <= 1'b1;
                bresp_q   <= wa_hit ? pwm_shutdown_pkg::RESP_OKAY
                                    : pwm_shutdown_pkg::RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
            if (ar_fire)
            begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= {24'h00_0000, rd_byte};
                rresp_q   <= ra_hit ? pwm_shutdown_pkg::RESP_OKAY
                                    : pwm_shutdown_pkg::RESP_SLVERR;
            end
            else if (rvalid_q && s_axi_rready)
            begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign irq           = irq_q;
endmodule

// File: test/pwm_auto_shutdown_checker.sv
// Checker of bus handshakes and reset state
`timescale 1ns/1ps
module pwm_auto_shutdown_checker
(
    input wire logic        aclk, aresetn, irq,                         // Clock, reset, irq
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, // Write request
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready,   // Write answer
    input wire logic        s_axi_arvalid, s_axi_arready,               // Read request
    input wire logic        s_axi_rvalid, s_axi_rready,                 // Read answer
    input wire logic [1:0]  s_axi_rresp,                                // Read response
    input wire logic [31:0] s_axi_rdata,                                // Read data
    input wire logic        output_a_oe, output_b_oe, output_c_oe, output_d_oe // Drives
);
    // ==========================
    // Handshake steps
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wt; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_rt; s_axi_arvalid && s_axi_arready; endsequence
    // ==========================
    // Properties
    property p_wresp; s_wt |-> ##2 s_axi_bvalid; endproperty
    property p_wbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_wdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
    property p_rresp; s_rt |=> s_axi_rvalid && !s_axi_arready; endproperty
    property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
    property p_rerr; s_axi_rvalid && s_axi_rresp[1] |-> s_axi_rdata == 32'h0; endproperty
    property p_rhigh; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    // Mode is cleared by reset, so no pin may be driven
    property p_rstoff; $rose(aresetn) |-> !irq && !(output_a_oe || output_b_oe ||
        output_c_oe || output_d_oe); endproperty
    a_wresp: assert property (p_wresp) else $error("write answer late");
    a_wbusy: assert property (p_wbusy) else $error("write ready while answering");
    a_wdone: assert property (p_wdone) else $error("write answer stuck");
    a_rresp: assert property (p_rresp) else $error("read answer late");
    a_rdone: assert property (p_rdone) else $error("read answer stuck");
    a_rerr: assert property (p_rerr) else $error("refused read has data");
    a_rhigh: assert property (p_rhigh) else $error("upper read bits set");
    a_rstoff: assert property (p_rstoff) else $error("pins driven after reset");
endmodule

// File: test/bridge_model.sv
// Far side: comparators, interrupt line and bridge pins with pull-downs
`timescale 1ns/1ps
module bridge_model
(
    input  wire logic [2:0] trip,              // Raw cmp1, cmp2, line
    input  wire logic [1:0] cmp_en,            // Comparator enables
    input  wire logic [3:0] pin_q,             // Pin levels D..A
    input  wire logic [3:0] pin_oe,            // Pin drives D..A
    output logic            comp1_out,         // Comparator 1
    output logic            comp2_out,         // Comparator 2
    output logic            ext_irq_zero_line, // Interrupt line
    output logic [3:0]      pin_lvl            // Wire levels
);
    // A disabled comparator idles low and cannot trip
    assign comp1_out = trip[0] & cmp_en[0];
    assign comp2_out = trip[1] & cmp_en[1];
    assign ext_irq_zero_line = trip[2];
    // Released pins fall to the pull-downs, keeping switches off
    assign pin_lvl = pin_q & pin_oe;
endmodule

// File: test/tb_pwm_auto_shutdown.sv
// Bench for the auto-shutdown PWM block
`timescale 1ns/1ps
module tb_pwm_auto_shutdown;
    // ==========================
    // Signals
    logic aclk = 0, aresetn = 0, por_reset = 1, s_axi_bready = 1, s_axi_rready = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF, pin_lvl;
    logic [2:0] trip = 0;
    logic [1:0] cmp_en = 0, s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic comp1_out, comp2_out, ext_irq_zero_line, output_a, output_b, output_c, output_d;
    logic output_a_oe, output_b_oe, output_c_oe, output_d_oe;
    int err_count = 0, total_checks = 0, cyc = 0;
    typedef struct packed { logic [7:0] a, rv, w; } row_t; // Address, reset, written
    row_t rows [8] = '{'{8'h04, 8'hFF, 8'h03}, '{8'h08, 8'h00, 8'h04}, '{8'h14, 8'h00, 8'h4C},
        '{8'h1C, 8'h00, 8'h55}, '{8'h10, 8'h00, 8'h7E}, '{8'h24, 8'h00, 8'h02},
        '{8'h28, 8'h00, 8'h01}, '{8'h18, 8'h00, 8'h01}};
    wire [3:0] oe_v = {output_d_oe, output_c_oe, output_b_oe, output_a_oe};
    pwm_auto_shutdown u_pwm_auto_shutdown (.*);
    bridge_model u_bridge_model (.pin_q({output_d, output_c, output_b, output_a}),
        .pin_oe(oe_v), .*);
    always #25 aclk = ~aclk;
    // Hang guard, far above the thousand or so cycles needed
    always @(posedge aclk) if (++cyc == 8000) begin err_count++; stop_test(); end
    // ==========================
    // Tasks
    task automatic chk(input logic [31:0] s, e, input string n);
        total_checks++;
        if (s !== e) begin err_count++; $display("FAIL %s exp %h got %h", n, e, s); end
    endtask
    task automatic wr(input logic [7:0] a, v);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, 24'h0, v, 2'b11};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic rc(input logic [7:0] a, e, input string n);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        if (n != "") chk(d, {24'h0, e}, n);
    endtask
    // Looks just after the edge, before any flop can follow
    task automatic pins(input logic [3:0] o, l);
        #1;
        chk(oe_v, o, "pin drive");
        chk(pin_lvl, l, "pin level");
    endtask
    task automatic rst(input logic p);
        {por_reset, aresetn} <= {p, 1'b0};
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ==========================
    // Sequence
    initial begin
        rst(1);
        foreach (rows[i]) rc(rows[i].a, rows[i].rv, "reset value");
        foreach (rows[i]) begin wr(rows[i].a, rows[i].w); rc(rows[i].a, rows[i].w, "readback"); end
        rc(8'h40, 8'h00, "unmapped data");
        chk(r, 2'b10, "unmapped read");
        wr(8'h40, 8'h5A);
        chk(r, 2'b10, "unmapped write");
        $display("done registers");
        cmp_en <= 2'b11;
        for (int s = 0; s < 8; s++) for (int t = 0; t < 3; t++) begin
            wr(8'h18, {1'b0, s[2:0], 4'h1});
            trip <= 3'b001 << t;
            if (s[t]) pins(4'hF, 4'hA);
            repeat (6) @(posedge aclk);
            trip <= 0;
            repeat (6) @(posedge aclk);
            if (s[t]) pins(4'hF, 4'hA);
            rc(8'h18, 8'h00, "");
            chk(d[7], s[t], "event flag");
            wr(8'h18, 8'h01);
            rc(8'h18, 8'h01, "flag clear");
        end
        $display("done sources");
        wr(8'h08, 8'h00);
        wr(8'h18, 8'h81);
        wr(8'h18, 8'h01);
        pins(4'hF, 4'hA);
        wr(8'h08, 8'h04);
        repeat (30) @(posedge aclk);
        pins(4'hF, 4'h9);
        rc(8'h20, 8'h00, "");
        chk(d[0], 1, "period match");
        wr(8'h08, 8'h00);
        wr(8'h14, 8'h8C);
        wr(8'h0C, 8'h00);
        pins(4'h3, 4'h0);
        repeat (300) @(posedge aclk);
        pins(4'h3, 4'h0);
        repeat (45) @(posedge aclk);
        pins(4'h3, 4'h2);
        wr(8'h14, 8'h4C);
        wr(8'h18, 8'h84);
        repeat (3) @(posedge aclk);
        pins(4'hF, 4'h5);
        chk(irq, 1, "irq raised");
        rc(8'h20, 8'h00, "");
        chk(d[1], 1, "event status");
        repeat (3) @(posedge aclk);
        chk(irq, 0, "irq cleared");
        wr(8'h18, 8'h00);
        wr(8'h24, 8'h00);
        wr(8'h18, 8'h8E);
        pins(4'h0, 4'h0);
        repeat (3) @(posedge aclk);
        chk(irq, 0, "irq masked");
        $display("done manual");
        wr(8'h28, 8'h00);
        wr(8'h18, 8'h41);
        trip <= 3'b100;
        repeat (8) @(posedge aclk);
        trip <= 0;
        repeat (6) @(posedge aclk);
        rc(8'h18, 8'h41, "line disabled");
        rst(0);
        rc(8'h1C, 8'h55, "dead band warm");
        rst(1);
        rc(8'h1C, 8'h00, "dead band cold");
        $display("done resets");
        stop_test();
    end
endmodule
bind pwm_auto_shutdown pwm_auto_shutdown_checker u_pwm_auto_shutdown_checker (.*);
